/* File: hdl/mbwsa_pkg.sv */
package mbwsa_pkg;

  // ----------------------------------------------------------------
  // Channels and states
  // ----------------------------------------------------------------
  localparam int NCH    = 3;
  localparam int CH_W   = 0;
  localparam int CH_R   = 1;
  localparam int CH_P   = 2;
  localparam int PAD_W  = 10;
  localparam int RG_CNT = 16;

  typedef enum logic {ST_IDLE, ST_ACT} mbwsa_state_t;

  typedef enum logic [3:0] {
    RG_NONE, RG_M0, RG_M1, RG_PF0, RG_PF1, RG_PF2,
    RG_L0, RG_OTP, RG_FLASH, RG_PWD, RG_BOOT
  } mbwsa_region_t;

  // ----------------------------------------------------------------
  // Memory map, 22-bit word addresses
  // ----------------------------------------------------------------
  localparam logic [21:0] M0_HI   = 22'h0003FF;
  localparam logic [21:0] M1_HI   = 22'h0007FF;
  localparam logic [21:0] PF0_HI  = 22'h001FFF;
  localparam logic [21:0] PF1_LO  = 22'h006000;
  localparam logic [21:0] PF1_HI  = 22'h006FFF;
  localparam logic [21:0] PF2_HI  = 22'h007FFF;
  localparam logic [21:0] L0_LO   = 22'h008000;
  localparam logic [21:0] L0_HI   = 22'h0083FF;
  localparam logic [21:0] OTP_LO  = 22'h3D7800;
  localparam logic [21:0] OTP_HI  = 22'h3D7BFF;
  localparam logic [21:0] FL_LO   = 22'h3F0000;
  localparam logic [21:0] PWD_LO  = 22'h3F7FF8;
  localparam logic [21:0] FL_HI   = 22'h3F7FFF;
  localparam logic [21:0] L0M_LO  = 22'h3F8000;
  localparam logic [21:0] L0M_HI  = 22'h3F83FF;
  localparam logic [21:0] BOOT_LO = 22'h3FE000;

  // ----------------------------------------------------------------
  // Wait states and reset values
  // ----------------------------------------------------------------
  localparam logic [4:0] WS_ZERO     = 5'h00;
  localparam logic [4:0] WS_PER_WR   = 5'h00;
  localparam logic [4:0] WS_PER_RD   = 5'h02;
  localparam logic [4:0] WS_PWD      = 5'h10;
  localparam logic [4:0] WS_OTP_MIN  = 5'h01;
  localparam logic [4:0] WS_RAND_MIN = 5'h01;
  localparam logic [4:0] WS_B2B      = 5'h01;
  localparam int         PAGE_LSB    = 3;
  localparam int         PAGE_W      = 22 - PAGE_LSB;
  localparam logic [1:0] PROT_RST    = 2'h3;

endpackage

/* File: hdl/mbwsa_top.sv */
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Priority: data write, program write, data read, program read, fetch.
// - One write channel; data write wins over program write.
// - One program read path; program read wins over fetch.
// - Program read bus has 22-bit address and 32-bit data.
// - Data read and write buses have 32-bit address and data.
// - Fetch, data read and data write complete together on distinct regions.
// - Low RAM blocks, frame zero and boot ROM take zero waits.
// - Wide peripheral frame: writes 0, reads 2 waits, stretched by ready.
// - Back-to-back writes to the wide peripheral frame add one stall cycle.
// - Narrow peripheral frame: writes 0, reads 2 waits, ready ignored.
// - Secure local RAM takes zero waits when no access conflicts.
// - OTP waits come from the OTP wait setting, at least one.
// - Flash paged and random waits; random at least one and paged.
// - Password locations always take sixteen waits.
// - Without protection a read may pass a pending write.
// - Protected frames hold reads until earlier writes have finished.
// - Protection is programmable and on for both frames after reset.
// - Bridge puts data buses on a 16-address-line peripheral bus.
// - Narrow peripheral frame refuses 32-bit accesses.
// - Wide peripheral frame takes 16-bit and 32-bit accesses.
module mbwsa_top
  import mbwsa_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  input  wire logic        fetch_req_i,
  input  wire logic [21:0] fetch_addr_i,
  input  wire logic        prd_req_i,
  input  wire logic [21:0] prd_addr_i,
  input  wire logic        drd_req_i,
  input  wire logic [31:0] drd_addr_i,
  input  wire logic        drd_wide_i,
  input  wire logic        dwr_req_i,
  input  wire logic [31:0] dwr_addr_i,
  input  wire logic        dwr_wide_i,
  input  wire logic [31:0] dwr_data_i,
  input  wire logic        pwr_req_i,
  input  wire logic [21:0] pwr_addr_i,
  input  wire logic [31:0] pwr_data_i,
  input  wire logic [3:0]  flash_paged_ws_i,
  input  wire logic [3:0]  flash_random_ws_i,
  input  wire logic [3:0]  otp_ws_i,
  input  wire logic [1:0]  prot_dis_i,
  input  wire logic [31:0] pm_rdata_i,
  input  wire logic [31:0] rm_rdata_i,
  input  wire logic [31:0] per_rdata_i,
  input  wire logic        per_ready_i,
  output logic             fetch_ack_o,
  output logic             prd_ack_o,
  output logic [31:0]      p_rdata_o,
  output logic             drd_ack_o,
  output logic [31:0]      drd_rdata_o,
  output logic             dwr_ack_o,
  output logic             pwr_ack_o,
  output logic [2:0]       acc_err_o,
  output logic [21:0]      pm_addr_o,
  output logic             pm_rd_o,
  output logic [3:0]       pm_sel_o,
  output logic [31:0]      rm_addr_o,
  output logic             rm_rd_o,
  output logic [3:0]       rm_sel_o,
  output logic [31:0]      wm_addr_o,
  output logic             wm_wr_o,
  output logic [3:0]       wm_sel_o,
  output logic [31:0]      wm_data_o,
  output logic [15:0]      per_addr_o,
  output logic [31:0]      per_wdata_o,
  output logic             per_rd_o,
  output logic             per_wr_o,
  output logic             per_wide_o,
  output logic             per_frame2_o
);

  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------
  function automatic mbwsa_region_t region_of(input logic [31:0] a, input logic dsp);
    logic [21:0] w;
    w = a[21:0];
    if (a[31:22] != '0)                      region_of = RG_NONE;
    else if (w <= M0_HI)                     region_of = RG_M0;
    else if (w <= M1_HI)                     region_of = RG_M1;
    else if (w <= PF0_HI)                    region_of = dsp ? RG_PF0 : RG_NONE;
    else if (w >= PF1_LO && w <= PF1_HI)     region_of = dsp ? RG_PF1 : RG_NONE;
    else if (w > PF1_HI && w <= PF2_HI)      region_of = dsp ? RG_PF2 : RG_NONE;
    else if (w >= L0_LO && w <= L0_HI)       region_of = RG_L0;
    else if (w >= L0M_LO && w <= L0M_HI)     region_of = RG_L0;
    else if (w >= OTP_LO && w <= OTP_HI)     region_of = RG_OTP;
    else if (w >= PWD_LO && w <= FL_HI)      region_of = RG_PWD;
    else if (w >= FL_LO && w < PWD_LO)       region_of = RG_FLASH;
    else if (w >= BOOT_LO)                   region_of = RG_BOOT;
    else                                     region_of = RG_NONE;
  endfunction

  // Password words live inside the flash array and both frames share the bridge
  function automatic mbwsa_region_t res_of(input mbwsa_region_t r);
    if (r == RG_PWD)      res_of = RG_FLASH;
    else if (r == RG_PF2) res_of = RG_PF1;
    else                  res_of = r;
  endfunction

  function automatic logic is_per(input mbwsa_region_t r);
    is_per = (r == RG_PF1) || (r == RG_PF2);
  endfunction

  function automatic logic [4:0] ws_of(input mbwsa_region_t r, input logic wr,
                                       input logic hit, input logic [3:0] pg,
                                       input logic [3:0] rn, input logic [3:0] ot);
    logic [4:0] m;
    m = ({1'b0, rn} > {1'b0, pg}) ? {1'b0, rn} : {1'b0, pg};
    if (m < WS_RAND_MIN)
      m = WS_RAND_MIN;
    case (r)
      RG_PF1, RG_PF2: ws_of = wr ? WS_PER_WR : WS_PER_RD;
      RG_OTP:   ws_of = ({1'b0, ot} < WS_OTP_MIN) ? WS_OTP_MIN : {1'b0, ot};
      RG_FLASH: ws_of = hit ? {1'b0, pg} : m;
      RG_PWD:   ws_of = WS_PWD;
      default:  ws_of = WS_ZERO;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Channel state
  // ----------------------------------------------------------------
  mbwsa_state_t          st      [NCH];
  mbwsa_state_t          next_st [NCH];
  mbwsa_region_t         rg      [NCH];
  mbwsa_region_t         next_rg [NCH];
  logic [4:0]            cnt     [NCH];
  logic [4:0]            next_cnt[NCH];
  logic [31:0]           adr     [NCH];
  logic [31:0]           next_adr[NCH];
  logic [PAGE_W-1:0]     page     [NCH];
  logic [PAGE_W-1:0]     next_page[NCH];
  logic [NCH-1:0]        kind, next_kind, wide, next_wide, bad, next_bad;
  logic [NCH-1:0]        ackp, next_ackp, pval, next_pval, done;
  logic [NCH-1:0]        c_req, c_kind, c_wide, c_dsp;
  logic [31:0]           c_addr[NCH];
  logic [31:0]           wdat, next_wdat;
  logic                  w_recent, next_w_recent;
  logic [1:0]            prot_en, next_prot_en;
  logic [RG_CNT-1:0]     busy;
  mbwsa_region_t         c_rg;
  mbwsa_region_t         c_res;
  logic                  hold;
  logic                  hit;
  logic [4:0]            ws;
  logic                  pw, pr;
  logic [31:0]           next_p_rdata, next_drd_rdata;

  // ----------------------------------------------------------------
  // Requester selection inside each channel
  // ----------------------------------------------------------------
  always_comb
  begin
    c_req[CH_W]  = dwr_req_i | pwr_req_i;
    c_kind[CH_W] = ~dwr_req_i;
    c_addr[CH_W] = dwr_req_i ? dwr_addr_i : {{PAD_W{1'b0}}, pwr_addr_i};
    c_wide[CH_W] = dwr_req_i ? dwr_wide_i : 1'b1;
    c_dsp[CH_W]  = dwr_req_i;
    c_req[CH_R]  = drd_req_i;
    c_kind[CH_R] = 1'b0;
    c_addr[CH_R] = drd_addr_i;
    c_wide[CH_R] = drd_wide_i;
    c_dsp[CH_R]  = 1'b1;
    c_req[CH_P]  = prd_req_i | fetch_req_i;
    c_kind[CH_P] = prd_req_i;
    c_addr[CH_P] = {{PAD_W{1'b0}}, prd_req_i ? prd_addr_i : fetch_addr_i};
    c_wide[CH_P] = 1'b1;
    c_dsp[CH_P]  = 1'b0;
  end

  // ----------------------------------------------------------------
  // Arbitration and wait-state counting
  // ----------------------------------------------------------------
  always_comb
  begin
    c_rg          = RG_NONE;
    c_res         = RG_NONE;
    hold          = 1'b0;
    hit           = 1'b0;
    ws            = WS_ZERO;
    next_wdat     = wdat;
    next_w_recent = w_recent;
    next_prot_en  = ~prot_dis_i;
    busy          = '0;
    for (int c = 0; c < NCH; c++)
    begin
      next_st[c]   = st[c];
      next_rg[c]   = rg[c];
      next_cnt[c]  = cnt[c];
      next_adr[c]  = adr[c];
      next_page[c] = page[c];
      next_kind[c] = kind[c];
      next_wide[c] = wide[c];
      next_bad[c]  = bad[c];
      next_pval[c] = pval[c];
      next_ackp[c] = 1'b0;
      done[c]      = 1'b0;
      if (st[c] == ST_ACT && rg[c] != RG_NONE)
        busy[res_of(rg[c])] = 1'b1;
    end
    // Lower index is higher priority, so a claim here blocks later channels
    for (int c = 0; c < NCH; c++)
    begin
      c_rg  = region_of(c_addr[c], c_dsp[c]);
      c_res = res_of(c_rg);
      hit   = pval[c] && (page[c] == c_addr[c][21:PAGE_LSB]);
      ws    = ws_of(c_rg, c == CH_W, hit, flash_paged_ws_i, flash_random_ws_i, otp_ws_i);
      // Reads to unprotected space may still overtake a queued write
      hold  = (c == CH_R) && is_per(c_rg) && prot_en[c_rg == RG_PF2]
              && (st[CH_W] != ST_IDLE || c_req[CH_W]);
      case (st[c])
        ST_IDLE:
        begin
          // ackp blocks a re-grant on the request that was just answered
          if (c_req[c] && !ackp[c] && !hold
              && !(c_rg != RG_NONE && busy[c_res]))
          begin
            next_st[c]   = ST_ACT;
            next_rg[c]   = c_rg;
            next_adr[c]  = c_addr[c];
            next_kind[c] = c_kind[c];
            next_wide[c] = c_wide[c];
            next_bad[c]  = (c_rg == RG_PF2) && c_wide[c];
            next_cnt[c]  = ws;
            if (c_rg != RG_NONE)
              busy[c_res] = 1'b1;
            if (c_rg == RG_FLASH)
            begin
              next_page[c] = c_addr[c][21:PAGE_LSB];
              next_pval[c] = 1'b1;
            end
            if (c == CH_W)
            begin
              next_wdat     = dwr_req_i ? dwr_data_i : pwr_data_i;
              next_w_recent = 1'b0;
              if (w_recent && c_rg == RG_PF1)
                next_cnt[c] = ws + WS_B2B;
            end
          end
          else if (c == CH_W && !c_req[c] && !ackp[c])
            next_w_recent = 1'b0;
        end
        ST_ACT:
        begin
          // Only the wide frame honours the peripheral ready
          if (cnt[c] == WS_ZERO && (rg[c] != RG_PF1 || per_ready_i || bad[c]))
          begin
            next_st[c]   = ST_IDLE;
            next_ackp[c] = 1'b1;
            done[c]      = 1'b1;
            if (c == CH_W)
              next_w_recent = (rg[c] == RG_PF1);
          end
          else if (cnt[c] != WS_ZERO)
            next_cnt[c] = cnt[c] - 5'h01;
        end
        default:
          next_st[c] = ST_IDLE;
      endcase
    end
    next_p_rdata   = done[CH_P] ? pm_rdata_i : p_rdata_o;
    next_drd_rdata = drd_rdata_o;
    if (done[CH_R])
      next_drd_rdata = is_per(rg[CH_R]) ? per_rdata_i : rm_rdata_i;
    pw = next_st[CH_W] == ST_ACT && is_per(next_rg[CH_W]) && !next_bad[CH_W];
    pr = next_st[CH_R] == ST_ACT && is_per(next_rg[CH_R]) && !next_bad[CH_R];
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      for (int c = 0; c < NCH; c++)
      begin
        st[c]   <= ST_IDLE;
        rg[c]   <= RG_NONE;
        cnt[c]  <= WS_ZERO;
        adr[c]  <= '0;
        page[c] <= '0;
      end
      kind         <= '0;
      wide         <= '0;
      bad          <= '0;
      ackp         <= '0;
      pval         <= '0;
      wdat         <= '0;
      w_recent     <= 1'b0;
      prot_en      <= PROT_RST;
      fetch_ack_o  <= 1'b0;
      prd_ack_o    <= 1'b0;
      drd_ack_o    <= 1'b0;
      dwr_ack_o    <= 1'b0;
      pwr_ack_o    <= 1'b0;
      acc_err_o    <= '0;
      p_rdata_o    <= '0;
      drd_rdata_o  <= '0;
      pm_addr_o    <= '0;
      pm_rd_o      <= 1'b0;
      pm_sel_o     <= '0;
      rm_addr_o    <= '0;
      rm_rd_o      <= 1'b0;
      rm_sel_o     <= '0;
      wm_addr_o    <= '0;
      wm_wr_o      <= 1'b0;
      wm_sel_o     <= '0;
      wm_data_o    <= '0;
      per_addr_o   <= '0;
      per_wdata_o  <= '0;
      per_rd_o     <= 1'b0;
      per_wr_o     <= 1'b0;
      per_wide_o   <= 1'b0;
      per_frame2_o <= 1'b0;
    end
    else
    begin
      for (int c = 0; c < NCH; c++)
      begin
        st[c]   <= next_st[c];
        rg[c]   <= next_rg[c];
        cnt[c]  <= next_cnt[c];
        adr[c]  <= next_adr[c];
        page[c] <= next_page[c];
      end
      kind         <= next_kind;
      wide         <= next_wide;
      bad          <= next_bad;
      ackp         <= next_ackp;
      pval         <= next_pval;
      wdat         <= next_wdat;
      w_recent     <= next_w_recent;
      prot_en      <= next_prot_en;
      dwr_ack_o    <= done[CH_W] & ~kind[CH_W];
      pwr_ack_o    <= done[CH_W] & kind[CH_W];
      drd_ack_o    <= done[CH_R];
      fetch_ack_o  <= done[CH_P] & ~kind[CH_P];
      prd_ack_o    <= done[CH_P] & kind[CH_P];
      acc_err_o    <= done & bad;
      p_rdata_o    <= next_p_rdata;
      drd_rdata_o  <= next_drd_rdata;
      pm_addr_o    <= next_adr[CH_P][21:0];
      pm_rd_o      <= next_st[CH_P] == ST_ACT && next_rg[CH_P] != RG_NONE;
      pm_sel_o     <= next_rg[CH_P];
      rm_addr_o    <= next_adr[CH_R];
      rm_rd_o      <= next_st[CH_R] == ST_ACT && next_rg[CH_R] != RG_NONE
                      && !is_per(next_rg[CH_R]);
      rm_sel_o     <= next_rg[CH_R];
      wm_addr_o    <= next_adr[CH_W];
      wm_wr_o      <= next_st[CH_W] == ST_ACT && next_rg[CH_W] != RG_NONE
                      && !is_per(next_rg[CH_W]);
      wm_sel_o     <= next_rg[CH_W];
      wm_data_o    <= next_wdat;
      // Writes and reads never share the bridge, the resource claim sees to it
      per_addr_o   <= pw ? next_adr[CH_W][15:0] : next_adr[CH_R][15:0];
      per_wdata_o  <= next_wdat;
      per_wr_o     <= pw;
      per_rd_o     <= pr & ~pw;
      per_wide_o   <= pw ? next_wide[CH_W] : next_wide[CH_R];
      per_frame2_o <= pw ? next_rg[CH_W] == RG_PF2 : next_rg[CH_R] == RG_PF2;
    end
  end

endmodule

`default_nettype wire

/* File: dv/mbwsa_top_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module mbwsa_top_properties
  import mbwsa_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  input  wire logic        fetch_ack_o,
  input  wire logic        prd_ack_o,
  input  wire logic        drd_ack_o,
  input  wire logic        dwr_ack_o,
  input  wire logic        pwr_ack_o,
  input  wire logic        pm_rd_o,
  input  wire logic [21:0] pm_addr_o,
  input  wire logic [3:0]  pm_sel_o,
  input  wire logic        rm_rd_o,
  input  wire logic [3:0]  rm_sel_o,
  input  wire logic        per_rd_o,
  input  wire logic        per_wr_o,
  input  wire logic        per_wide_o,
  input  wire logic        per_frame2_o
);
  // ----
  // Strobe length, too long for a repetition
  // ----
  logic [4:0] rcnt;
  logic [4:0] next_rcnt;
  always_comb next_rcnt = rm_rd_o ? rcnt + 5'h01 : 5'h00;
  always_ff @(posedge mclk_i) rcnt <= rst_i ? 5'h00 : next_rcnt;

  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  a_write_one_grant:
    assert property (!(dwr_ack_o && pwr_ack_o)) else $error("two writes together");
  a_prog_one_path:
    assert property (!(fetch_ack_o && prd_ack_o)) else $error("two program reads together");
  a_fixed_zero_wait:
    assert property ($rose(rm_rd_o) && rm_sel_o inside {RG_M0, RG_M1, RG_PF0, RG_BOOT}
      |=> !rm_rd_o && drd_ack_o) else $error("fixed area not zero wait");
  a_local_ram_zero:
    assert property ($rose(pm_rd_o) && pm_sel_o == RG_L0
      |=> !pm_rd_o && (fetch_ack_o || prd_ack_o)) else $error("local ram not zero wait");
  a_narrow_rd_two:
    assert property ($rose(per_rd_o) && per_frame2_o
      |=> per_rd_o ##1 per_rd_o ##1 (!per_rd_o && drd_ack_o)) else $error("narrow read length");
  a_narrow_wr_zero:
    assert property ($rose(per_wr_o) && per_frame2_o |=> !per_wr_o && dwr_ack_o)
      else $error("narrow write length");
  a_narrow_no_wide:
    assert property ((per_rd_o || per_wr_o) && per_frame2_o |-> !per_wide_o)
      else $error("wide access on narrow frame");
  a_pwd_sixteen:
    assert property ($fell(rm_rd_o) && $past(rm_sel_o) == RG_PWD |-> rcnt == 5'h11)
      else $error("password wait count");
  a_otp_one_wait:
    assert property ($rose(rm_rd_o) && rm_sel_o == RG_OTP |=> rm_rd_o)
      else $error("otp below one wait");
  a_addr_stable:
    assert property (pm_rd_o && $past(pm_rd_o) |-> $stable(pm_addr_o))
      else $error("program address moved");
endmodule

bind mbwsa_top mbwsa_top_properties u_props (.mclk_i, .rst_i, .fetch_ack_o, .prd_ack_o,
  .drd_ack_o, .dwr_ack_o, .pwr_ack_o, .pm_rd_o, .pm_addr_o, .pm_sel_o, .rm_rd_o,
  .rm_sel_o, .per_rd_o, .per_wr_o, .per_wide_o, .per_frame2_o);
`default_nettype wire

/* File: dv/mbwsa_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
module mbwsa_mem_model (
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  input  wire logic [3:0]  slow_i,
  input  wire logic        pm_rd_i,
  input  wire logic [21:0] pm_addr_i,
  input  wire logic        rm_rd_i,
  input  wire logic [31:0] rm_addr_i,
  input  wire logic        per_rd_i,
  input  wire logic        per_wr_i,
  input  wire logic [15:0] per_addr_i,
  output logic             per_ready_o,
  output logic [31:0]      pm_rdata_o,
  output logic [31:0]      rm_rdata_o,
  output logic [31:0]      per_rdata_o
);
  logic [3:0] cnt;
  logic       tg;

  function automatic logic [31:0] dv(input logic [31:0] a);
    return a * 32'h9E3779B1 + 32'h2545F491;
  endfunction

  // Idle read lines show the inverse, so a sample taken late cannot match
  assign pm_rdata_o  = pm_rd_i ? dv({10'h000, pm_addr_i}) : ~dv({10'h000, pm_addr_i});
  assign rm_rdata_o  = rm_rd_i ? dv(rm_addr_i) : ~dv(rm_addr_i);
  assign per_rdata_o = per_rd_i ? dv({16'h0000, per_addr_i}) : ~dv({16'h0000, per_addr_i});
  // Ready withheld for the first slow_i strobe cycles, toggling while idle
  assign per_ready_o = (per_rd_i || per_wr_i) ? (cnt >= slow_i) : tg;

  always_ff @(posedge mclk_i)
  begin
    tg  <= rst_i ? 1'b0 : ~tg;
    cnt <= (rst_i || !(per_rd_i || per_wr_i)) ? 4'h0 : cnt + 4'h1;
  end
endmodule
`default_nettype wire

/* File: dv/mbwsa_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module mbwsa_top_tb
  import mbwsa_pkg::*;
;
  logic             mclk_i = 1'b0;
  logic             rst_i = 1'b1;
  logic [4:0]       req = 5'h00;
  logic [4:0]       wd = 5'h00;
  logic [31:0]      adr [5];
  logic [31:0]      dat = 32'h0;
  logic [31:0]      a;
  logic [3:0]       pg = 4'h0;
  logic [3:0]       rn = 4'h0;
  logic [3:0]       ot = 4'h0;
  logic [3:0]       slow = 4'h0;
  logic [1:0]       prot = 2'h0;
  logic [2:0]       er;
  int               t [5];
  int               num_errors = 0;
  int               checked = 0;
  int               cyc = 0;
  int               n;
  int               rs;
  wire logic [4:0]  ack;
  wire logic [31:0] p_rdata_o, drd_rdata_o, wm_data_o, per_wdata_o, rm_addr_o, wm_addr_o;
  wire logic [31:0] pm_rdata_i, rm_rdata_i, per_rdata_i;
  wire logic [21:0] pm_addr_o;
  wire logic [15:0] per_addr_o;
  wire logic [2:0]  acc_err_o;
  wire logic        pm_rd_o, rm_rd_o, wm_wr_o, per_rd_o, per_wr_o, per_ready_i;
  localparam logic [31:0] ZB [5] = '{32'h0, 32'h400, 32'h800, 32'h8000, 32'h3FE000};

  always #2 mclk_i = ~mclk_i;

  mbwsa_top dut (.mclk_i, .rst_i, .fetch_req_i(req[0]), .fetch_addr_i(adr[0][21:0]),
    .prd_req_i(req[1]), .prd_addr_i(adr[1][21:0]), .drd_req_i(req[2]), .drd_addr_i(adr[2]),
    .drd_wide_i(wd[2]), .dwr_req_i(req[3]), .dwr_addr_i(adr[3]), .dwr_wide_i(wd[3]),
    .dwr_data_i(dat), .pwr_req_i(req[4]), .pwr_addr_i(adr[4][21:0]), .pwr_data_i(dat),
    .flash_paged_ws_i(pg), .flash_random_ws_i(rn), .otp_ws_i(ot), .prot_dis_i(prot),
    .pm_rdata_i, .rm_rdata_i, .per_rdata_i, .per_ready_i, .fetch_ack_o(ack[0]),
    .prd_ack_o(ack[1]), .p_rdata_o, .drd_ack_o(ack[2]), .drd_rdata_o, .dwr_ack_o(ack[3]),
    .pwr_ack_o(ack[4]), .acc_err_o, .pm_addr_o, .pm_rd_o, .pm_sel_o(), .rm_addr_o, .rm_rd_o,
    .rm_sel_o(), .wm_addr_o, .wm_wr_o, .wm_sel_o(), .wm_data_o, .per_addr_o, .per_wdata_o,
    .per_rd_o, .per_wr_o, .per_wide_o(), .per_frame2_o());

  mbwsa_mem_model u_mem (.mclk_i, .rst_i, .slow_i(slow), .pm_rd_i(pm_rd_o),
    .pm_addr_i(pm_addr_o), .rm_rd_i(rm_rd_o), .rm_addr_i(rm_addr_o), .per_rd_i(per_rd_o),
    .per_wr_i(per_wr_o), .per_addr_i(per_addr_o), .per_ready_o(per_ready_i),
    .pm_rdata_o(pm_rdata_i), .rm_rdata_o(rm_rdata_i), .per_rdata_o(per_rdata_i));

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e)
    begin
      num_errors++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  function automatic int mx(input int x, input int y);
    return x > y ? x : y;
  endfunction

  task automatic wt(input int c);
    n = 0;
    do
    begin
      @(negedge mclk_i);
      n++;
    end while (!ack[c] && n < 60);
  endtask

  // Raise every channel in m together, drop each in its own ack cycle
  task automatic grp(input logic [4:0] m);
    logic [4:0]  d;
    int          k;
    logic [31:0] mk;
    d = 5'h00;
    k = 0;
    mk = (adr[2][21:0] inside {[PF1_LO:PF2_HI]} && !wd[2]) ? 32'hFFFF : 32'hFFFFFFFF;
    @(negedge mclk_i);
    dat = $urandom;
    req = m;
    while (d != m && k < 60)
    begin
      @(negedge mclk_i);
      k++;
      if (wm_wr_o) chk(wm_data_o, dat);
      if (per_rd_o) chk(per_addr_o, adr[2][15:0]);
      if (per_wr_o) chk(per_wdata_o[15:0], dat[15:0]);
      for (int c = 0; c < 5; c++)
        if (m[c] && !d[c] && ack[c])
        begin
          d[c] = 1'b1;
          t[c] = k;
          req[c] = 1'b0;
          er = acc_err_o;
          if (c < 2) chk(p_rdata_o, u_mem.dv({10'h000, adr[c][21:0]}));
          if (c == 2) chk(drd_rdata_o & mk, u_mem.dv(adr[2]) & mk);
          if (c > 2) chk(wm_addr_o, adr[c]);
        end
    end
    chk(d, m);
  endtask

  task automatic one(input int c, input logic [31:0] ad, input logic w, input int e);
    adr[c] = ad;
    wd[c] = w;
    grp(5'h01 << c);
    chk(t[c], e);
  endtask

  always @(posedge mclk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      num_errors++;
      wrap_up();
    end
  end

  initial
  begin
    rs = $urandom(40098);
    foreach (adr[i]) adr[i] = 32'h0;
    repeat (16) @(posedge mclk_i);
    @(negedge mclk_i);
    rst_i = 1'b0;
    foreach (ZB[i])
      for (int c = 0; c < 5; c++)
        if (!(c < 2 && i == 2)) one(c, ZB[i] + ($urandom & 32'h3FF), 1'b1, 2);
    for (int k = 0; k < 4; k++)
    begin
      pg = 4'($urandom);
      rn = 4'($urandom);
      ot = 4'($urandom);
      n = k[0] ? 0 : 2;
      a = {10'h000, FL_LO} + 32'h100 * k + ($urandom & 32'h7);
      one(n, a, 1'b1, 2 + mx(mx(rn, pg), 1));
      one(n, a ^ 32'h1, 1'b1, 2 + pg);
      one(2, {10'h000, OTP_LO} + k, 1'b1, 2 + mx(ot, 1));
      one(n, {10'h000, PWD_LO} + k, 1'b1, 18);
    end
    for (int s = 0; s < 5; s += 4)
    begin
      slow = 4'(s);
      one(2, 32'h6010, 1'b1, 2 + mx(2, s));
      one(2, 32'h6012, 1'b0, 2 + mx(2, s));
      one(2, 32'h7010, 1'b0, 4);
      one(3, 32'h7020, 1'b0, 2);
      one(3, 32'h6020, 1'b0, 2 + s);
    end
    slow = 4'h0;
    one(3, 32'h7030, 1'b1, 2);
    chk(er, 3'h1);
    // Let the dropped request reach an edge before asking again
    @(negedge mclk_i);
    adr[3] = 32'h6040;
    req[3] = 1'b1;
    wt(3);
    chk(n, 2);
    adr[3] = 32'h6044;
    wt(3);
    chk(n, 4);
    req[3] = 1'b0;
    repeat (3) @(negedge mclk_i);
    one(3, 32'h6048, 1'b1, 2);
    // Pairs of winner and loser: data over program write, program read over fetch, write over read
    for (int i = 0; i < 3; i++)
    begin
      n = i == 1 ? 1 : 3;
      rs = i == 0 ? 4 : (i == 1 ? 0 : 2);
      adr[n] = i == 0 ? 32'h20 : (i == 1 ? 32'h410 : 32'h8010);
      adr[rs] = adr[n] + 32'h4;
      grp((5'h01 << n) | (5'h01 << rs));
      chk(t[n] < t[rs], 1'b1);
    end
    adr[0] = 32'h3FE010;
    adr[2] = 32'h10;
    adr[3] = 32'h420;
    grp(5'h0D);
    chk({t[0][3:0], t[2][3:0], t[3][3:0]}, 12'h222);
    for (int p = 0; p < 4; p++)
      for (int f = 0; f < 2; f++)
      begin
        prot = 2'(p);
        repeat (2) @(negedge mclk_i);
        adr[3] = 32'h10;
        adr[2] = f ? 32'h7050 : 32'h6050;
        wd = 5'h00;
        grp(5'h0C);
        chk(t[2] == 4, p[f]);
      end
    wrap_up();
  end
endmodule
`default_nettype wire
